// File: logic/cid_core.sv
// Control instruction and block I/O decoder with interrupt response.
// Assumes an opcode stream from a fetch unit that follows pc_out, and
// memory and port read channels that answer with a one-cycle valid.
`timescale 1ns/1ps
module cid_core (
  input  wire logic               clock_in,
  input  wire logic               rst_in,
  input  wire logic               op_valid_in,
  input  wire logic [7:0]         op_in,
  output logic                    op_ready_out,
  output logic [15:0]             pc_out,
  input  wire logic               regs_load_in,
  input  wire cid_pkg::cid_regs_t regs_in,
  input  wire logic [7:0]         page_reg_in,
  output cid_pkg::cid_regs_t      regs_out,
  output logic                    zero_flag_out,
  output logic                    int_enable_out,
  output cid_pkg::cid_mode_t      int_mode_out,
  output logic                    halted_out,
  input  wire logic               int_req_in,
  output logic                    int_ack_out,
  input  wire logic               vec_valid_in,
  input  wire logic [7:0]         vec_data_in,
  output logic                    inject_valid_out,
  output logic [7:0]              inject_op_out,
  output logic                    mem_rd_req_out,
  output logic [15:0]             mem_addr_out,
  input  wire logic               mem_rd_valid_in,
  input  wire logic [7:0]         mem_rd_data_in,
  output logic                    io_rd_req_out,
  output logic [15:0]             io_addr_out,
  input  wire logic               io_rd_valid_in,
  input  wire logic [7:0]         io_rd_data_in,
  output logic                    wr_valid_out,
  output cid_pkg::cid_wr_t        wr_out,
  input  wire logic               wr_ready_in
);
  import cid_pkg::*;

  function automatic logic is_block(input logic [7:0] op);
    is_block = ((op & BLK_MASK) == BLK_MATCH);
  endfunction

  cid_state_t  state_ff, nxt_state;
  cid_regs_t   regs_ff, nxt_regs;
  cid_mode_t   mode_ff, nxt_mode;
  cid_wr_t     wrq_ff, nxt_wrq;
  logic [15:0] pc_ff, nxt_pc;
  logic [15:0] addr_ff, nxt_addr;
  logic [15:0] target_ff, nxt_target;
  logic [7:0]  op2_ff, nxt_op2;
  logic [7:0]  inject_ff, nxt_inject;
  logic        inject_v_ff, nxt_inject_v;
  logic        iff_ff, nxt_iff;
  logic        zero_ff, nxt_zero;
  logic        take_int;
  logic        op_take;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        wr_take;
  cid_wr_t     buf_in;
  logic [7:0]  cnt_dec;
  logic [7:0]  cur_op;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts are only taken between instructions, never mid-sequence.
  assign take_int     = int_req_in && iff_ff && (state_ff == S_FETCH || state_ff == S_HALT);
  // A pending injected byte owns the fetch slot, so the stream waits one cycle.
  assign op_ready_out = !take_int && !inject_v_ff &&
                        (state_ff == S_FETCH || state_ff == S_PREFIX || state_ff == S_IMM);
  assign op_take      = op_valid_in && op_ready_out;
  assign cur_op       = inject_v_ff ? inject_ff : op_in;
  assign cnt_dec      = regs_ff.count_reg - BYTE_ONE;
  assign buf_in_valid = (state_ff == S_WRITE || state_ff == S_PUSH_HI ||
                         state_ff == S_PUSH_LO);
  assign wr_take      = buf_in_valid && buf_in_ready;

  always_comb begin
    buf_in = wrq_ff;
    if (state_ff == S_PUSH_HI) begin
      buf_in = '{is_io: 1'b0, addr: regs_ff.stack_ptr - WORD_ONE, data: pc_ff[15:8]};
    end else if (state_ff == S_PUSH_LO) begin
      buf_in = '{is_io: 1'b0, addr: regs_ff.stack_ptr - WORD_TWO, data: pc_ff[7:0]};
    end
  end

  always_comb begin
    nxt_state    = state_ff;
    nxt_regs     = regs_ff;
    nxt_mode     = mode_ff;
    nxt_wrq      = wrq_ff;
    nxt_pc       = pc_ff;
    nxt_addr     = addr_ff;
    nxt_target   = target_ff;
    nxt_op2      = op2_ff;
    nxt_inject   = inject_ff;
    nxt_inject_v = 1'b0;
    nxt_iff      = iff_ff;
    nxt_zero     = zero_ff;
    if (take_int) begin
      nxt_iff = 1'b0;
      if (mode_ff == MODE_ONE) begin
        nxt_target = RESTART_ADDR;
        nxt_state  = S_PUSH_HI;
      end else begin
        nxt_state = S_VEC;
      end
    end else begin
      case (state_ff)
        S_FETCH: begin
          if (op_take || inject_v_ff) begin
            nxt_pc = inject_v_ff ? pc_ff : pc_ff + WORD_ONE;
            case (cur_op)
              OP_HALT:    nxt_state = S_HALT;
              OP_LOCKOUT: nxt_iff = 1'b0;
              OP_UNLOCK:  nxt_iff = 1'b1;
              OP_PREFIX:  nxt_state = S_PREFIX;
              OP_IMM_IN, OP_IMM_OUT: begin
                nxt_op2   = cur_op;
                nxt_state = S_IMM;
              end
              default: ;
            endcase
          end else if (regs_load_in) begin
            nxt_regs = regs_in;
          end
        end
        S_PREFIX: begin
          if (op_take) begin
            nxt_pc    = pc_ff + WORD_ONE;
            nxt_op2   = op_in;
            nxt_state = S_FETCH;
            if (op_in == OP_VECTOR_MODE_0) begin
              nxt_mode = MODE_ZERO;
            end else if (op_in == OP_VECTOR_MODE_1) begin
              nxt_mode = MODE_ONE;
            end else if (op_in == OP_VECTOR_MODE_2) begin
              nxt_mode = MODE_TWO;
            end else if (is_block(op_in) && op_in[BLK_OUT_BIT]) begin
              nxt_addr  = regs_ff.pointer_pair;
              nxt_state = S_MEM_RD;
            end else if (is_block(op_in)) begin
              nxt_addr  = {regs_ff.count_reg, regs_ff.port_reg};
              nxt_state = S_IO_RD;
            end
          end
        end
        S_IMM: begin
          if (op_take) begin
            nxt_pc = pc_ff + WORD_ONE;
            nxt_addr = {regs_ff.acc, op_in};
            if (op2_ff == OP_IMM_IN) begin
              nxt_state = S_IO_RD;
            end else begin
              nxt_wrq   = '{is_io: 1'b1, addr: {regs_ff.acc, op_in}, data: regs_ff.acc};
              nxt_state = S_WRITE;
            end
          end
        end
        S_IO_RD: begin
          if (io_rd_valid_in) begin
            if (op2_ff == OP_IMM_IN) begin
              nxt_regs.acc = io_rd_data_in;
              nxt_state    = S_FETCH;
            end else begin
              nxt_wrq   = '{is_io: 1'b0, addr: regs_ff.pointer_pair, data: io_rd_data_in};
              nxt_state = S_WRITE;
            end
          end
        end
        S_MEM_RD: begin
          if (mem_rd_valid_in) begin
            nxt_wrq = '{is_io: 1'b1, addr: {regs_ff.count_reg, regs_ff.port_reg},
                        data: mem_rd_data_in};
            nxt_state = S_WRITE;
          end
        end
        S_WRITE: begin
          if (wr_take) begin
            nxt_state = S_FETCH;
            if (is_block(op2_ff)) begin
              nxt_regs.pointer_pair = op2_ff[BLK_DOWN_BIT] ?
                                      regs_ff.pointer_pair - WORD_ONE :
                                      regs_ff.pointer_pair + WORD_ONE;
              nxt_regs.count_reg = cnt_dec;
              if (!op2_ff[BLK_RPT_BIT]) begin
                nxt_zero = (cnt_dec == BYTE_ZERO);
              end else if (cnt_dec != BYTE_ZERO) begin
                nxt_pc = pc_ff - WORD_TWO;
              end
            end
          end
        end
        S_HALT: ;
        S_VEC: begin
          if (vec_valid_in) begin
            if (mode_ff == MODE_ZERO) begin
              nxt_inject   = vec_data_in;
              nxt_inject_v = 1'b1;
              nxt_state    = S_FETCH;
            end else begin
              nxt_addr  = {page_reg_in, vec_data_in};
              nxt_state = S_TBL_LO;
            end
          end
        end
        S_TBL_LO: begin
          if (mem_rd_valid_in) begin
            nxt_target[7:0] = mem_rd_data_in;
            nxt_addr        = addr_ff + WORD_ONE;
            nxt_state       = S_TBL_HI;
          end
        end
        S_TBL_HI: begin
          if (mem_rd_valid_in) begin
            nxt_target[15:8] = mem_rd_data_in;
            nxt_state        = S_PUSH_HI;
          end
        end
        S_PUSH_HI: begin
          if (wr_take) begin
            nxt_state = S_PUSH_LO;
          end
        end
        S_PUSH_LO: begin
          if (wr_take) begin
            nxt_regs.stack_ptr = regs_ff.stack_ptr - WORD_TWO;
            nxt_pc             = target_ff;
            nxt_state          = S_FETCH;
          end
        end
        default: nxt_state = S_FETCH;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff    <= S_FETCH;
      regs_ff     <= '0;
      mode_ff     <= MODE_ZERO;
      wrq_ff      <= '0;
      pc_ff       <= WORD_ZERO;
      addr_ff     <= WORD_ZERO;
      target_ff   <= WORD_ZERO;
      op2_ff      <= BYTE_ZERO;
      inject_ff   <= BYTE_ZERO;
      inject_v_ff <= 1'b0;
      iff_ff      <= 1'b0;
      zero_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      regs_ff     <= nxt_regs;
      mode_ff     <= nxt_mode;
      wrq_ff      <= nxt_wrq;
      pc_ff       <= nxt_pc;
      addr_ff     <= nxt_addr;
      target_ff   <= nxt_target;
      op2_ff      <= nxt_op2;
      inject_ff   <= nxt_inject;
      inject_v_ff <= nxt_inject_v;
      iff_ff      <= nxt_iff;
      zero_ff     <= nxt_zero;
    end
  end

  assign pc_out           = pc_ff;
  assign regs_out         = regs_ff;
  assign zero_flag_out    = zero_ff;
  assign int_enable_out   = iff_ff;
  assign int_mode_out     = mode_ff;
  assign halted_out       = (state_ff == S_HALT);
  assign int_ack_out      = (state_ff == S_VEC);
  assign inject_valid_out = inject_v_ff;
  assign inject_op_out    = inject_ff;
  assign mem_rd_req_out   = (state_ff == S_MEM_RD || state_ff == S_TBL_LO ||
                             state_ff == S_TBL_HI);
  assign io_rd_req_out    = (state_ff == S_IO_RD);
  assign mem_addr_out     = addr_ff;
  assign io_addr_out      = addr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry write buffer; a stalled receiver backs the sequencer up.
  cid_wr_t    mem_ff [2];
  cid_wr_t    nxt_mem [2];
  logic       wptr_ff, nxt_wptr;
  logic       rptr_ff, nxt_rptr;
  logic [1:0] fill_ff, nxt_fill;
  logic       wr_pop;

  assign buf_in_ready = (fill_ff != BUF_DEPTH);
  assign wr_valid_out = (fill_ff != 2'h0);
  assign wr_pop       = wr_valid_out && wr_ready_in;

  always_comb begin
    nxt_mem  = mem_ff;
    nxt_wptr = wptr_ff;
    nxt_rptr = rptr_ff;
    nxt_fill = fill_ff;
    if (wr_take) begin
      nxt_mem[wptr_ff] = buf_in;
      nxt_wptr         = !wptr_ff;
    end
    if (wr_pop) begin
      nxt_rptr = !rptr_ff;
    end
    nxt_fill = fill_ff + {1'b0, wr_take} - {1'b0, wr_pop};
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wptr_ff   <= 1'b0;
      rptr_ff   <= 1'b0;
      fill_ff   <= 2'h0;
    end else begin
      mem_ff    <= nxt_mem;
      wptr_ff   <= nxt_wptr;
      rptr_ff   <= nxt_rptr;
      fill_ff   <= nxt_fill;
    end
  end

  assign wr_out = mem_ff[rptr_ff];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_nop_pc_only: assert property (
    (state_ff == S_FETCH && op_take && op_in == OP_NO_OPERATION) |=>
    (pc_ff == $past(pc_ff) + WORD_ONE) && $stable(regs_ff) && $stable(iff_ff) && $stable(zero_ff))
    else $error("no-operation changed more than the counter");
  a_halt_holds: assert property (
    (state_ff == S_HALT && !take_int) |=> state_ff == S_HALT)
    else $error("halt left without an interrupt");
  a_lockout_unlock: assert property (
    (state_ff == S_FETCH && op_take && (op_in == OP_LOCKOUT || op_in == OP_UNLOCK)) |=>
    iff_ff == ($past(op_in) == OP_UNLOCK))
    else $error("interrupt enable not updated");
  a_mode0_inject: assert property (
    (int_ack_out && vec_valid_in && mode_ff == MODE_ZERO) |=>
    inject_valid_out && inject_op_out == $past(vec_data_in))
    else $error("supplied instruction not passed on");
  a_inject_executes: assert property (
    (state_ff == S_FETCH && inject_v_ff && inject_ff == OP_UNLOCK) |=> iff_ff && $stable(pc_ff))
    else $error("supplied instruction not executed");
  a_mode1_restart: assert property (
    (take_int && mode_ff == MODE_ONE) |=> state_ff == S_PUSH_HI && target_ff == RESTART_ADDR)
    else $error("restart target wrong");
  a_push_then_jump: assert property (
    (state_ff == S_PUSH_LO && wr_take) |=> pc_ff == target_ff && state_ff == S_FETCH &&
    regs_ff.stack_ptr == $past(regs_ff.stack_ptr) - WORD_TWO)
    else $error("jump without completed push");
  a_table_address: assert property (
    (int_ack_out && vec_valid_in && mode_ff == MODE_TWO) |=>
    mem_rd_req_out && mem_addr_out == {$past(page_reg_in), $past(vec_data_in)})
    else $error("table address wrong");
  a_block_io_addr: assert property (
    (io_rd_req_out && is_block(op2_ff)) |-> io_addr_out == {regs_ff.count_reg, regs_ff.port_reg})
    else $error("block port address wrong");
  a_block_count: assert property (
    (state_ff == S_WRITE && wr_take && is_block(op2_ff)) |=>
    regs_ff.count_reg == $past(cnt_dec))
    else $error("count not decremented");
  a_block_zero: assert property (
    (state_ff == S_WRITE && wr_take && is_block(op2_ff) && !op2_ff[BLK_RPT_BIT]) |=>
    zero_flag_out == (regs_ff.count_reg == BYTE_ZERO))
    else $error("zero flag wrong");
  a_repeat_rewind: assert property (
    (state_ff == S_WRITE && wr_take && is_block(op2_ff) && op2_ff[BLK_RPT_BIT] &&
     cnt_dec != BYTE_ZERO) |=> pc_ff == $past(pc_ff) - WORD_TWO)
    else $error("repeat form did not rewind");

  c_halt_wake: cover property (state_ff == S_HALT ##[1:50] take_int);
  c_mode2_call: cover property (state_ff == S_TBL_HI ##[1:20] state_ff == S_PUSH_LO);
  c_buffer_full: cover property (fill_ff == BUF_DEPTH);
endmodule // cid_core

// File: logic/cid_pkg.sv
// Constants, opcodes and carrier types for the control and block I/O decoder.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package cid_pkg;
  localparam logic [7:0]  OP_NO_OPERATION    = 8'h00;
  localparam logic [7:0]  OP_HALT            = 8'h76;
  localparam logic [7:0]  OP_LOCKOUT         = 8'hF3;
  localparam logic [7:0]  OP_UNLOCK          = 8'hFB;
  localparam logic [7:0]  OP_PREFIX          = 8'hED;
  localparam logic [7:0]  OP_IMM_IN          = 8'hDB;
  localparam logic [7:0]  OP_IMM_OUT         = 8'hD3;
  localparam logic [7:0]  OP_VECTOR_MODE_0   = 8'h46;
  localparam logic [7:0]  OP_VECTOR_MODE_1   = 8'h56;
  localparam logic [7:0]  OP_VECTOR_MODE_2   = 8'h5E;
  // Block group: 101R_D01O, R repeat, D down, O output.
  localparam logic [7:0]  BLK_MASK           = 8'hE6;
  localparam logic [7:0]  BLK_MATCH          = 8'hA2;
  localparam int          BLK_OUT_BIT        = 0;
  localparam int          BLK_DOWN_BIT       = 3;
  localparam int          BLK_RPT_BIT        = 4;
  localparam logic [15:0] RESTART_ADDR       = 16'h0038;
  localparam logic [15:0] WORD_ONE           = 16'h0001;
  localparam logic [15:0] WORD_TWO           = 16'h0002;
  localparam logic [7:0]  BYTE_ONE           = 8'h01;
  localparam logic [7:0]  BYTE_ZERO          = 8'h00;
  localparam logic [15:0] WORD_ZERO          = 16'h0000;
  localparam logic [1:0]  BUF_DEPTH          = 2'h2;

  typedef enum logic [1:0] {
    MODE_ZERO = 2'h0,
    MODE_ONE  = 2'h1,
    MODE_TWO  = 2'h2
  } cid_mode_t;

  typedef enum logic [3:0] {
    S_FETCH   = 4'h0,
    S_PREFIX  = 4'h1,
    S_IO_RD   = 4'h3,
    S_WRITE   = 4'h2,
    S_MEM_RD  = 4'h6,
    S_IMM     = 4'h7,
    S_HALT    = 4'h5,
    S_VEC     = 4'h4,
    S_TBL_LO  = 4'hC,
    S_TBL_HI  = 4'hD,
    S_PUSH_HI = 4'hF,
    S_PUSH_LO = 4'hE
  } cid_state_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] pointer_pair;
    logic [7:0]  count_reg;
    logic [7:0]  port_reg;
    logic [15:0] stack_ptr;
  } cid_regs_t;

  typedef struct packed {
    logic        is_io;
    logic [15:0] addr;
    logic [7:0]  data;
  } cid_wr_t;
endpackage

// File: verif/cid_far_model.sv
// Far side model: memory and port read channels, vector source, write sink.
// Assumes the core holds each read request and its address until valid.
`timescale 1ns/1ps
module cid_far_model (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [1:0]  knob_in,
  input  wire logic [7:0]  vec_in,
  input  wire logic        mem_rd_req_in,
  input  wire logic [15:0] mem_addr_in,
  output logic             mem_rd_valid_out,
  output logic [7:0]       mem_rd_data_out,
  input  wire logic        io_rd_req_in,
  input  wire logic [15:0] io_addr_in,
  output logic             io_rd_valid_out,
  output logic [7:0]       io_rd_data_out,
  input  wire logic        int_ack_in,
  output logic             vec_valid_out,
  output logic [7:0]       vec_data_out,
  output logic             wr_ready_out
);
  logic [7:0] mem_byte;
  logic [7:0] io_byte;
  assign mem_byte = mem_addr_in[7:0] ^ mem_addr_in[15:8] ^ 8'h5A;
  assign io_byte  = io_addr_in[7:0] + io_addr_in[15:8] + 8'h3C;
  // Idle data is inverted so a read outside the valid cycle never matches.
  assign mem_rd_data_out = mem_rd_valid_out ? mem_byte : ~mem_byte;
  assign io_rd_data_out  = io_rd_valid_out ? io_byte : ~io_byte;
  assign vec_data_out = vec_valid_out ? vec_in : ~vec_in;
  assign wr_ready_out = ~knob_in[1];
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mem_rd_valid_out <= 1'b0;
      io_rd_valid_out  <= 1'b0;
      vec_valid_out    <= 1'b0;
    end else begin
      mem_rd_valid_out <= mem_rd_req_in && !mem_rd_valid_out && !knob_in[0];
      io_rd_valid_out  <= io_rd_req_in && !io_rd_valid_out && !knob_in[0];
      vec_valid_out    <= int_ack_in && !vec_valid_out && !knob_in[0];
    end
  end
endmodule // cid_far_model

// File: verif/testbench.sv
// Random and directed bench for the control and block I/O decoder.
// Assumes cid_pkg, cid_core and cid_far_model are compiled before it.
`timescale 1ns/1ps
module testbench;
  import cid_pkg::*;
  logic        clock_in, rst_in, op_valid_in, regs_load_in, int_req_in, run;
  logic [7:0]  op_in, page_reg_in, vec, last_inject, inject_op, vec_data;
  logic [7:0]  mem_rd_data, io_rd_data;
  logic [1:0]  knob;
  logic [15:0] stop_pc, pc, mem_addr, io_addr, last_io;
  logic        op_ready, zero_flag, int_enable, halted, int_ack, vec_valid;
  logic        inject_valid, mem_rd_req, mem_rd_valid, io_rd_req, io_rd_valid;
  logic        wr_valid, wr_ready;
  cid_mode_t   int_mode;
  cid_regs_t   regs_in, regs_out, r;
  cid_wr_t     wr;
  cid_wr_t     wq[$];
  integer      seed, errors, n_compared, n_inject;
  logic [7:0]  prog [0:65535];

  cid_core dut (.clock_in(clock_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
    .op_in(op_in), .op_ready_out(op_ready), .pc_out(pc), .regs_load_in(regs_load_in),
    .regs_in(regs_in), .page_reg_in(page_reg_in), .regs_out(regs_out),
    .zero_flag_out(zero_flag), .int_enable_out(int_enable), .int_mode_out(int_mode),
    .halted_out(halted), .int_req_in(int_req_in), .int_ack_out(int_ack),
    .vec_valid_in(vec_valid), .vec_data_in(vec_data), .inject_valid_out(inject_valid),
    .inject_op_out(inject_op), .mem_rd_req_out(mem_rd_req), .mem_addr_out(mem_addr),
    .mem_rd_valid_in(mem_rd_valid), .mem_rd_data_in(mem_rd_data),
    .io_rd_req_out(io_rd_req), .io_addr_out(io_addr), .io_rd_valid_in(io_rd_valid),
    .io_rd_data_in(io_rd_data), .wr_valid_out(wr_valid), .wr_out(wr),
    .wr_ready_in(wr_ready));
  cid_far_model far (.clock_in(clock_in), .rst_in(rst_in), .knob_in(knob),
    .vec_in(vec), .mem_rd_req_in(mem_rd_req), .mem_addr_in(mem_addr),
    .mem_rd_valid_out(mem_rd_valid), .mem_rd_data_out(mem_rd_data),
    .io_rd_req_in(io_rd_req), .io_addr_in(io_addr), .io_rd_valid_out(io_rd_valid),
    .io_rd_data_out(io_rd_data), .int_ack_in(int_ack), .vec_valid_out(vec_valid),
    .vec_data_out(vec_data), .wr_ready_out(wr_ready));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////////////
  // The fetch side follows pc_out and stops at the end of each program.
  always @(negedge clock_in) begin
    knob <= 2'($random(seed));
    op_valid_in <= run && (pc !== stop_pc);
    op_in <= prog[pc];
  end
  always @(posedge clock_in) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back(wr);
    if (io_rd_valid === 1'b1 && io_rd_req === 1'b1) last_io = io_addr;
    if (inject_valid === 1'b1) begin
      n_inject++;
      last_inject = inject_op;
    end
  end
  function automatic logic [7:0] fm(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function automatic logic [7:0] fio(input logic [15:0] a);
    return a[7:0] + a[15:8] + 8'h3C;
  endfunction
  task automatic print_verdict;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic chk_wr(input cid_wr_t exp);
    n_compared++;
    if (wq.size() == 0) begin
      errors++;
      $display("MISMATCH %0t write missing, exp %0h", $time, exp);
    end else if (wq[0] !== exp) begin
      errors++;
      $display("MISMATCH %0t write got %0h exp %0h", $time, wq[0], exp);
    end
    if (wq.size() > 0) wq.pop_front();
  endtask
  task automatic wait_until(input logic [15:0] t, input logic h);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clock_in);
      if (pc === t && wr_valid === 1'b0 && (h ? halted : op_ready) === 1'b1) return;
    end
    errors++;
    $display("MISMATCH %0t timeout waiting for pc %0h", $time, t);
    print_verdict();
  endtask
  task automatic exec(input logic [7:0] b0, input logic [7:0] b1, input int n,
                      input logic h);
    logic [15:0] p;
    p = pc;
    prog[p] = b0;
    prog[p + 16'h0001] = b1;
    stop_pc = p + 16'(n);
    run = 1'b1;
    wait_until(stop_pc, h);
    run = 1'b0;
  endtask
  task automatic load(input cid_regs_t v);
    @(negedge clock_in);
    regs_in = v;
    regs_load_in = 1'b1;
    @(negedge clock_in);
    regs_load_in = 1'b0;
  endtask
  task automatic irq;
    int i;
    @(negedge clock_in);
    int_req_in = 1'b1;
    for (i = 0; i < 200 && int_enable !== 1'b0; i++) @(negedge clock_in);
    int_req_in = 1'b0;
    chk(int_enable, 0, "interrupt not taken");
    if (int_enable !== 1'b0) print_verdict();
  endtask
  task automatic chk_call(input logic [15:0] ret, input logic [15:0] sp,
                          input logic [15:0] tgt);
    wait_until(tgt, 1'b0);
    chk_wr('{1'b0, sp - WORD_ONE, ret[15:8]});
    chk_wr('{1'b0, sp - WORD_TWO, ret[7:0]});
    chk(regs_out.stack_ptr, sp - WORD_TWO, "stack");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int i, j, k, n;
    logic [15:0] a, sp, t;
    logic [7:0] op;
    seed = 2527;
    errors = 0;
    n_compared = 0;
    n_inject = 0;
    rst_in = 1'b1;
    {op_valid_in, regs_load_in, int_req_in, run} = 4'h0;
    {op_in, page_reg_in, vec, last_inject, knob, stop_pc} = '0;
    regs_in = '0;
    for (i = 0; i < 65536; i++) prog[i] = 8'h00;
    repeat (20) @(posedge clock_in);
    @(negedge clock_in);
    rst_in = 1'b0;
    chk({pc, int_enable, int_mode, halted, wr_valid}, 0, "reset state");
    r = 56'({$random(seed), $random(seed)});
    sp = r.stack_ptr;
    load(r);
    exec(OP_NO_OPERATION, 8'h00, 1, 1'b0);
    chk(regs_out, r, "no-op registers");
    chk({zero_flag, halted, 32'(wq.size())}, 0, "no-op side effects");
    // Locked out: a held request must be ignored.
    exec(OP_UNLOCK, 8'h00, 1, 1'b0);
    chk(int_enable, 1, "unlock");
    exec(OP_LOCKOUT, 8'h00, 1, 1'b0);
    int_req_in = 1'b1;
    repeat (20) @(negedge clock_in);
    int_req_in = 1'b0;
    chk({int_enable, int_ack, pc}, {1'b0, 1'b0, stop_pc}, "lockout");
    // Fixed restart out of halt.
    exec(OP_PREFIX, OP_VECTOR_MODE_1, 2, 1'b0);
    chk(int_mode, MODE_ONE, "mode one");
    exec(OP_UNLOCK, 8'h00, 1, 1'b0);
    exec(OP_HALT, 8'h00, 1, 1'b1);
    repeat (20) @(negedge clock_in);
    chk({halted, pc}, {1'b1, stop_pc}, "halt holds");
    irq();
    chk_call(stop_pc, sp, RESTART_ADDR);
    chk(halted, 0, "halt released");
    sp = sp - WORD_TWO;
    // Table call.
    exec(OP_UNLOCK, 8'h00, 1, 1'b0);
    exec(OP_PREFIX, OP_VECTOR_MODE_2, 2, 1'b0);
    chk(int_mode, MODE_TWO, "mode two");
    page_reg_in = 8'($random(seed));
    vec = 8'($random(seed));
    t = {page_reg_in, vec};
    irq();
    chk_call(stop_pc, sp, {fm(t + WORD_ONE), fm(t)});
    sp = sp - WORD_TWO;
    // Injected instruction re-enables interrupts when executed.
    exec(OP_PREFIX, OP_VECTOR_MODE_0, 2, 1'b0);
    chk(int_mode, MODE_ZERO, "mode zero");
    exec(OP_UNLOCK, 8'h00, 1, 1'b0);
    vec = OP_UNLOCK;
    k = n_inject;
    irq();
    for (j = 0; j < 200 && n_inject == k; j++) @(negedge clock_in);
    chk(n_inject - k, 1, "injection seen");
    if (n_inject == k) print_verdict();
    chk(last_inject, OP_UNLOCK, "injected byte");
    repeat (4) @(negedge clock_in);
    chk(int_enable, 1, "injected unlock ran");
    exec(OP_LOCKOUT, 8'h00, 1, 1'b0);
    // Immediate port in and out.
    r = 56'({$random(seed), $random(seed)});
    load(r);
    op = 8'($random(seed));
    exec(OP_IMM_IN, op, 2, 1'b0);
    chk(last_io, {r.acc, op}, "imm in address");
    r.acc = fio({r.acc, op});
    chk(regs_out, r, "imm in result");
    exec(OP_IMM_OUT, ~op, 2, 1'b0);
    chk_wr('{1'b1, {r.acc, ~op}, r.acc});
    // All eight block forms, count one for the first two, repeat counts one to four.
    for (i = 0; i < 8; i++) begin
      op = BLK_MATCH | {3'h0, i[2], i[1], 2'h0, i[0]};
      r = 56'({$random(seed), $random(seed)});
      if (i[2]) r.count_reg = {6'h00, r.count_reg[1:0]} + BYTE_ONE;
      if (i < 2) r.count_reg = BYTE_ONE;
      load(r);
      exec(OP_PREFIX, op, 2, 1'b0);
      n = i[2] ? int'(r.count_reg) : 1;
      for (k = 0; k < n; k++) begin
        a = {r.count_reg, r.port_reg};
        if (i[0]) chk_wr('{1'b1, a, fm(r.pointer_pair)});
        else chk_wr('{1'b0, r.pointer_pair, fio(a)});
        r.pointer_pair = i[1] ? r.pointer_pair - WORD_ONE : r.pointer_pair + WORD_ONE;
        r.count_reg = r.count_reg - BYTE_ONE;
      end
      chk(regs_out, r, "block registers");
      if (!i[2]) chk(zero_flag, r.count_reg == BYTE_ZERO, "zero flag");
    end
    chk(wq.size(), 0, "extra writes");
    print_verdict();
  end
endmodule // testbench
